// ### logic/fapc_top.sv
// Flash access, divider, block protection and event flag control
`timescale 1ns/100ps
module fapc_top
  import fapc_pkg::*;
(
  input  wire logic        sys_clk_in,      // System clock, 100 MHz
  input  wire logic        rst_in,          // Async reset, high
  input  wire logic [7:0]  io_addr_in,      // I/O register address
  input  wire logic        io_wr_in,        // I/O write strobe
  input  wire logic        io_rd_in,        // I/O read strobe
  input  wire logic [7:0]  io_wdata_in,     // I/O write data
  output logic [7:0]       io_rdata_out,    // I/O read data, next cycle
  input  wire logic        wp_in,           // Write-protect pin, high asserted
  input  wire logic        mem_req_in,      // Memory-space access request pulse
  output logic             mem_ack_out,     // Access completes after wait states
  output logic             mem_refuse_out,  // Access blocked, memory space off
  input  wire logic        wr_req_in,       // Array write request pulse
  input  wire logic [17:0] wr_addr_in,      // Array byte address of write
  input  wire logic        wr_info_in,      // Write targets the info page
  output logic             wr_grant_out,    // Write may proceed
  input  wire logic        pe_req_in,       // Page erase request pulse
  input  wire logic [6:0]  pe_page_in,      // Page number to erase
  input  wire logic        pe_info_in,      // Erase targets the info page
  output logic             pe_grant_out,    // Page erase may proceed
  input  wire logic        me_req_in,       // Bulk erase request pulse
  output logic             me_grant_out,    // Bulk erase may proceed
  input  wire logic        op_done_in,      // Erase or row program finished pulse
  input  wire logic        rp_active_in,    // Row program in progress
  output logic             rp_abort_out,    // Clear row_program_start pulse
  output logic             fclk_en_out,     // Controller clock enable pulse
  output logic             irq_done_out,    // Completion interrupt request
  output logic             irq_err_out      // Error interrupt request
);
  import fapc_pkg::*;

  // Block lookup shared by write and page erase checks
  function automatic logic blk_prot(input logic [7:0] mask, input logic [2:0] blk, input logic wp);
    blk_prot = mask[blk] || ((blk == 3'h0) && wp);
  endfunction : blk_prot

  // Register state
  logic [2:0] wait_cnt_r;
  logic       mem_en_r;
  logic [7:0] controller_clock_divider_r;
  logic [7:0] block_protect_mask_r;
  logic       completion_irq_enable_r;
  logic       error_irq_enable_r;
  logic       done_flag_r;
  logic       write_violation_flag_r;
  logic       row_program_timeout_flag_r;
  logic       page_erase_violation_flag_r;
  logic       bulk_erase_violation_flag_r;
  logic       key_half_r;
  logic       unlocked_r;
  logic [2:0] acc_cnt_r;
  logic       acc_busy_r;

  // Address decode
  logic wr_ctrl, wr_fdiv, wr_prot, wr_irq, wr_key, rd_irq;
  assign wr_ctrl = io_wr_in && (io_addr_in == FAPC_CTRL_ADDR);
  assign wr_fdiv = io_wr_in && (io_addr_in == FAPC_FDIV_ADDR);
  assign wr_prot = io_wr_in && (io_addr_in == FAPC_PROT_ADDR);
  assign wr_irq  = io_wr_in && (io_addr_in == FAPC_IRQ_ADDR);
  assign wr_key  = io_wr_in && (io_addr_in == FAPC_KEY_ADDR);
  assign rd_irq  = io_rd_in && (io_addr_in == FAPC_IRQ_ADDR);

  // Protection decisions
  logic wr_blocked, pe_blocked, me_blocked, any_prot;
  assign any_prot   = (block_protect_mask_r != 8'h00) || wp_in;
  assign wr_blocked = !wr_info_in &&
                      blk_prot(block_protect_mask_r, wr_addr_in[FAPC_BLK_MSB:FAPC_BLK_LSB], wp_in);
  assign pe_blocked = !pe_info_in &&
                      blk_prot(block_protect_mask_r,
                               pe_page_in[FAPC_PG_BLK_MSB:FAPC_PG_BLK_LSB], wp_in);
  // Any protection blocks the whole bulk erase, info page included
  assign me_blocked = any_prot;

  // Divider and row program watchdog
  logic fclk_tick, rp_expire;
  fapc_clk_div u_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .div_in     (controller_clock_divider_r),
    .tick_out   (fclk_tick)
  );
  fapc_rp_timer u_rpt (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tick_in    (fclk_tick),
    .active_in  (rp_active_in),
    .expire_out (rp_expire)
  );

  // Read mux; reserved bits are zero
  logic [7:0] rd_mux;
  assign rd_mux = (io_addr_in == FAPC_CTRL_ADDR) ? {wait_cnt_r, 1'b0, mem_en_r, 3'h0} :
                  (io_addr_in == FAPC_FDIV_ADDR) ? controller_clock_divider_r :
                  (io_addr_in == FAPC_PROT_ADDR) ? block_protect_mask_r :
                  (io_addr_in == FAPC_IRQ_ADDR)  ? {completion_irq_enable_r, error_irq_enable_r, done_flag_r, 1'b0,
                                                    write_violation_flag_r, row_program_timeout_flag_r,
                                                    page_erase_violation_flag_r, bulk_erase_violation_flag_r} :
                  8'h00;

  // Flag next values: a new event beats the read clear
  logic done_nxt, wrv_nxt, rpt_nxt, pgv_nxt, mev_nxt, any_err_nxt;
  assign done_nxt = op_done_in || (done_flag_r && !rd_irq);
  assign wrv_nxt  = (wr_req_in && wr_blocked) || (write_violation_flag_r && !rd_irq);
  assign rpt_nxt  = rp_expire || (row_program_timeout_flag_r && !rd_irq);
  assign pgv_nxt  = (pe_req_in && pe_blocked) || (page_erase_violation_flag_r && !rd_irq);
  assign mev_nxt  = (me_req_in && me_blocked) || (bulk_erase_violation_flag_r && !rd_irq);
  assign any_err_nxt = wrv_nxt || rpt_nxt || pgv_nxt || mev_nxt;

  // Control register: wait count and memory enable
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_cnt_r <= FAPC_WAIT_RST;
      mem_en_r   <= FAPC_EN_RST;
    end else if (wr_ctrl) begin
      wait_cnt_r <= io_wdata_in[FAPC_WAIT_MSB:FAPC_WAIT_LSB];
      mem_en_r   <= io_wdata_in[FAPC_EN_BIT];
    end
  end

  // Key sequence: only back-to-back I/O writes count
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_half_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (io_wr_in) begin
      key_half_r <= wr_key && (io_wdata_in == FAPC_KEY_FIRST);
      if (wr_fdiv || wr_prot) unlocked_r <= 1'b0;
      else if (wr_key && key_half_r && (io_wdata_in == FAPC_KEY_SECOND)) unlocked_r <= 1'b1;
    end
  end

  // Guarded registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      controller_clock_divider_r <= FAPC_FDIV_RST;
      block_protect_mask_r       <= FAPC_PROT_RST;
    end else begin
      if (wr_fdiv && unlocked_r) controller_clock_divider_r <= io_wdata_in;
      if (wr_prot) block_protect_mask_r <= unlocked_r ? io_wdata_in : FAPC_PROT_ALL;
    end
  end

  // Interrupt enables and event flags
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      completion_irq_enable_r     <= 1'b0;
      error_irq_enable_r          <= 1'b0;
      done_flag_r                 <= 1'b0;
      write_violation_flag_r      <= 1'b0;
      row_program_timeout_flag_r  <= 1'b0;
      page_erase_violation_flag_r <= 1'b0;
      bulk_erase_violation_flag_r <= 1'b0;
    end else begin
      if (wr_irq) begin
        completion_irq_enable_r <= io_wdata_in[FAPC_COMPLETION_IRQ_ENABLE_BIT];
        error_irq_enable_r      <= io_wdata_in[FAPC_ERROR_IRQ_ENABLE_BIT];
      end
      done_flag_r                 <= done_nxt;
      write_violation_flag_r      <= wrv_nxt;
      row_program_timeout_flag_r  <= rpt_nxt;
      page_erase_violation_flag_r <= pgv_nxt;
      bulk_erase_violation_flag_r <= mev_nxt;
    end
  end

  // Memory-space wait state counter
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_busy_r <= 1'b0;
      acc_cnt_r  <= 3'h0;
    end else if (acc_busy_r) begin
      acc_cnt_r  <= acc_cnt_r - 3'h1;
      acc_busy_r <= (acc_cnt_r != 3'h0);
    end else if (mem_req_in && mem_en_r) begin
      acc_busy_r <= 1'b1;
      acc_cnt_r  <= wait_cnt_r;
    end
  end

  // Registered outputs; irq terms use next flag values so they track the flags
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_rdata_out   <= 8'h00;
      mem_ack_out    <= 1'b0;
      mem_refuse_out <= 1'b0;
      wr_grant_out   <= 1'b0;
      pe_grant_out   <= 1'b0;
      me_grant_out   <= 1'b0;
      rp_abort_out   <= 1'b0;
      fclk_en_out    <= 1'b0;
      irq_done_out   <= 1'b0;
      irq_err_out    <= 1'b0;
    end else begin
      io_rdata_out   <= io_rd_in ? rd_mux : 8'h00;
      mem_ack_out    <= acc_busy_r && (acc_cnt_r == 3'h0);
      mem_refuse_out <= mem_req_in && !mem_en_r && !acc_busy_r;
      wr_grant_out   <= wr_req_in && !wr_blocked;
      pe_grant_out   <= pe_req_in && !pe_blocked;
      me_grant_out   <= me_req_in && !me_blocked;
      rp_abort_out   <= rp_expire;
      fclk_en_out    <= fclk_tick;
      irq_done_out   <= done_nxt && completion_irq_enable_r && !wr_irq || done_nxt && wr_irq
                        && io_wdata_in[FAPC_COMPLETION_IRQ_ENABLE_BIT];
      irq_err_out    <= any_err_nxt && (wr_irq ? io_wdata_in[FAPC_ERROR_IRQ_ENABLE_BIT] : error_irq_enable_r);
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_key_pair;
    wr_key && io_wdata_in == FAPC_KEY_FIRST ##1 wr_key && io_wdata_in == FAPC_KEY_SECOND;
  endsequence
  sequence s_mem_req;
    mem_req_in && mem_en_r && !acc_busy_r;
  endsequence

  // Wait states and memory enable
  AST_WAIT_ZERO: assert property (s_mem_req and wait_cnt_r == 3'h0 |-> ##2 mem_ack_out)
    else $error("zero wait access not acked in two cycles");
  AST_WAIT_FOUR: assert property (s_mem_req and wait_cnt_r == 3'h4
                                  |-> ##1 !mem_ack_out [*5] ##1 mem_ack_out)
    else $error("four wait access timing wrong");
  AST_MEM_OFF: assert property (mem_req_in && !mem_en_r && !acc_busy_r |=> mem_refuse_out && !mem_ack_out)
    else $error("disabled memory access not refused");
  // Key sequence and guarded registers
  AST_UNLOCK: assert property (s_key_pair ##1 wr_fdiv |=> controller_clock_divider_r == $past(io_wdata_in))
    else $error("divider not written after key");
  AST_LOCKED_DIV: assert property (wr_fdiv && !unlocked_r |=> $stable(controller_clock_divider_r))
    else $error("locked divider changed");
  AST_PROT_FORCE: assert property (wr_prot && !unlocked_r |=> block_protect_mask_r == FAPC_PROT_ALL)
    else $error("locked protect write did not force all ones");
  AST_RELOCK: assert property ((wr_fdiv || wr_prot) |=> !unlocked_r)
    else $error("guarded write did not relock");
  // Protection and violation flags
  AST_BOOT_WP: assert property (wr_req_in && wp_in && !wr_info_in && wr_addr_in[17:15] == 3'h0
                                |=> !wr_grant_out && write_violation_flag_r)
    else $error("boot write under pin protect");
  AST_PE_VIO: assert property (pe_req_in && pe_blocked |=> !pe_grant_out && page_erase_violation_flag_r)
    else $error("protected page erase granted");
  AST_ME_VIO: assert property (me_req_in && any_prot |=> !me_grant_out && bulk_erase_violation_flag_r)
    else $error("bulk erase granted under protection");
  // Event flags and interrupt requests
  AST_DONE_SET: assert property (op_done_in |=> done_flag_r)
    else $error("done flag missed");
  AST_RD_CLEAR: assert property (rd_irq && !op_done_in && !rp_expire
                                 && !wr_req_in && !pe_req_in && !me_req_in
                                 |=> !done_flag_r && !row_program_timeout_flag_r && $stable(error_irq_enable_r))
    else $error("read did not clear flags");
  AST_TIMEOUT: assert property (rp_expire |=> rp_abort_out && row_program_timeout_flag_r)
    else $error("timeout did not abort");
  AST_ERR_IRQ: assert property (error_irq_enable_r && page_erase_violation_flag_r && !wr_irq
                                ##1 page_erase_violation_flag_r |-> irq_err_out)
    else $error("error irq missing");
  AST_DONE_IRQ: assert property (completion_irq_enable_r && done_flag_r && !rd_irq && !wr_irq
                                 |=> irq_done_out)
    else $error("completion irq dropped");

  // Further protection, read-back, interrupt and divider checks
  AST_WRITE_VIOLATION_FLAG: assert property (wr_req_in && wr_blocked |=> !wr_grant_out && write_violation_flag_r)
    else $error("protected write granted");
  AST_WP_BULK: assert property (me_req_in && wp_in |=> !me_grant_out && bulk_erase_violation_flag_r)
    else $error("bulk erase granted under pin protect");
  AST_INFO_OPEN: assert property (pe_req_in && pe_info_in |=> pe_grant_out)
    else $error("info page erase refused");
  AST_RSV_ZERO: assert property (io_rd_in && io_addr_in == FAPC_CTRL_ADDR
                                 |=> io_rdata_out[4] == 1'b0 && io_rdata_out[2:0] == 3'h0)
    else $error("reserved control bits read nonzero");
  AST_RD_DROP: assert property (rd_irq && !op_done_in |=> !irq_done_out)
    else $error("completion irq held after read");
  AST_DIV_ONE: assert property (fclk_en_out && controller_clock_divider_r == 8'h01 |=> fclk_en_out)
    else $error("divide by one did not tick every cycle");
endmodule : fapc_top

// ### logic/fapc_pkg.sv
// Package of offsets, field positions, reset values and counts for the flash access/protect control
package fapc_pkg;
  // I/O register offsets
  localparam logic [7:0] FAPC_KEY_ADDR  = 8'hF5;
  localparam logic [7:0] FAPC_CTRL_ADDR = 8'hF8;
  localparam logic [7:0] FAPC_FDIV_ADDR = 8'hF9;
  localparam logic [7:0] FAPC_PROT_ADDR = 8'hFA;
  localparam logic [7:0] FAPC_IRQ_ADDR  = 8'hFB;
  // Unlock key bytes, in order
  localparam logic [7:0] FAPC_KEY_FIRST  = 8'hB6;
  localparam logic [7:0] FAPC_KEY_SECOND = 8'h49;
  // Control register fields
  localparam int         FAPC_WAIT_MSB  = 7;
  localparam int         FAPC_WAIT_LSB  = 5;
  localparam int         FAPC_EN_BIT    = 3;
  localparam logic [2:0] FAPC_WAIT_RST  = 3'h4;
  localparam logic       FAPC_EN_RST    = 1'b1;
  // Divider and protection reset values
  localparam logic [7:0] FAPC_FDIV_RST  = 8'h01;
  localparam logic [7:0] FAPC_PROT_RST  = 8'hFF;
  localparam logic [7:0] FAPC_PROT_ALL  = 8'hFF;
  // Interrupt register fields
  localparam int         FAPC_COMPLETION_IRQ_ENABLE_BIT = 7;
  localparam int         FAPC_ERROR_IRQ_ENABLE_BIT  = 6;
  localparam int         FAPC_DONE_BIT     = 5;
  localparam int         FAPC_WRVIO_BIT    = 3;
  localparam int         FAPC_RPTMO_BIT    = 2;
  localparam int         FAPC_PGVIO_BIT    = 1;
  localparam int         FAPC_MEVIO_BIT    = 0;
  // Array geometry: 32KB blocks, 2KB pages
  localparam int         FAPC_BLK_MSB      = 17;
  localparam int         FAPC_BLK_LSB      = 15;
  localparam int         FAPC_PG_BLK_MSB   = 6;
  localparam int         FAPC_PG_BLK_LSB   = 4;
  // Row program timeout in controller clocks
  localparam logic [12:0] FAPC_RP_TIMEOUT  = 13'h1300;
endpackage : fapc_pkg

// ### logic/fapc_clk_div.sv
// Divider making the flash controller clock enable from the system clock
`timescale 1ns/100ps
module fapc_clk_div (
  input  wire logic       sys_clk_in,     // System clock
  input  wire logic       rst_in,         // Async reset, high
  input  wire logic [7:0] div_in,         // Divide ratio, 0 acts as 256
  output logic            tick_out        // One-cycle controller clock enable
);
  import fapc_pkg::*;

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       wrap;

  // Wrap at ratio minus one; 8-bit wrap makes 0 mean 256
  assign wrap    = (cnt_r >= (div_in - 8'h01));
  assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;

  // Counter and registered enable
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r    <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      tick_out <= wrap;
    end
  end
endmodule : fapc_clk_div

// ### logic/fapc_rp_timer.sv
// Row program watchdog counting controller clock enables
`timescale 1ns/100ps
module fapc_rp_timer (
  input  wire logic sys_clk_in,     // System clock
  input  wire logic rst_in,         // Async reset, high
  input  wire logic tick_in,        // Controller clock enable
  input  wire logic active_in,      // Row program in progress
  output logic      expire_out      // One-cycle timeout pulse
);
  import fapc_pkg::*;

  logic [12:0] cnt_r;
  logic        fired_r;
  logic        hit;

  // Fires once at the last controller clock of the allowance
  assign hit = active_in && !fired_r && tick_in && (cnt_r == FAPC_RP_TIMEOUT - 13'h0001);

  // Count restarts whenever the operation ends
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r      <= 13'h0000;
      fired_r    <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= hit;
      if (!active_in) begin
        cnt_r   <= 13'h0000;
        fired_r <= 1'b0;
      end else begin
        if (hit) fired_r <= 1'b1;
        if (tick_in && !fired_r) cnt_r <= cnt_r + 13'h0001;
      end
    end
  end
endmodule : fapc_rp_timer

// ### testbench/fapc_cpu_model.sv
// CPU model driving the I/O register path of the flash control block
`timescale 1ns/100ps
module fapc_cpu_model (
  input  wire logic       sys_clk_in,   // System clock
  output logic [7:0]      io_addr_out,  // I/O register address
  output logic            io_wr_out,    // I/O write strobe
  output logic            io_rd_out,    // I/O read strobe
  output logic [7:0]      io_wdata_out, // I/O write data
  input  wire logic [7:0] io_rdata_in   // I/O read data
);
  import fapc_pkg::*;
  // Bus idle from time zero
  initial begin
    io_addr_out  = 8'h00;
    io_wr_out    = 1'b0;
    io_rd_out    = 1'b0;
    io_wdata_out = 8'h00;
  end
  // One write strobe, launched and released on falling edges
  task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    io_addr_out  = addr;
    io_wdata_out = data;
    io_wr_out    = 1'b1;
    @(negedge sys_clk_in);
    io_wr_out    = 1'b0;
    io_wdata_out = ~data; // Released data must not still look valid
  endtask : io_write
  // One read strobe; data stands the cycle after the taking edge
  task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge sys_clk_in);
    io_addr_out = addr;
    io_rd_out   = 1'b1;
    @(negedge sys_clk_in);
    io_rd_out = 1'b0;
    data      = io_rdata_in;
  endtask : io_read
  // Key pair directly ahead of each guarded write, since every guarded write relocks
  // Three back-to-back writes with the strobe held high, so the key pair is truly consecutive
  task automatic unlock_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_in);
    io_addr_out  = FAPC_KEY_ADDR;
    io_wdata_out = FAPC_KEY_FIRST;
    io_wr_out    = 1'b1;
    @(negedge sys_clk_in);
    io_wdata_out = FAPC_KEY_SECOND;
    @(negedge sys_clk_in);
    io_addr_out  = addr;
    io_wdata_out = data;
    @(negedge sys_clk_in);
    io_wr_out    = 1'b0;
    io_wdata_out = ~data;
  endtask : unlock_write
endmodule : fapc_cpu_model

// ### testbench/flash_access_protect_control_test.sv
// Self-checking bench for the flash access, divider, protection and event flag control
`timescale 1ns/100ps
module flash_access_protect_control_test;
  import fapc_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic [7:0]  io_addr, io_wdata, io_rdata, rd, g, n;
  logic        io_wr, io_rd, mem_ack, mem_refuse, wr_grant, pe_grant, me_grant;
  logic        rp_abort, fclk_en, irq_done, irq_err;
  logic        wp = 1'b0, mem_req = 1'b0, wr_req = 1'b0, wr_info = 1'b0, pe_req = 1'b0;
  logic        pe_info = 1'b0, me_req = 1'b0, op_done = 1'b0, rp_active = 1'b0;
  logic [17:0] wr_addr = 18'h00000;
  logic [6:0]  pe_page = 7'h00;
  logic [15:0] rst_rows [6] = '{16'hF888, 16'hF901, 16'hFAFF, 16'hFB00, 16'hF500, 16'hF000};
  int          fails = 0, check_count = 0, cnt;

  fapc_cpu_model cpu (.sys_clk_in(sys_clk_in), .io_addr_out(io_addr), .io_wr_out(io_wr),
    .io_rd_out(io_rd), .io_wdata_out(io_wdata), .io_rdata_in(io_rdata));
  fapc_top dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .io_addr_in(io_addr), .io_wr_in(io_wr),
    .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata), .wp_in(wp),
    .mem_req_in(mem_req), .mem_ack_out(mem_ack), .mem_refuse_out(mem_refuse), .wr_req_in(wr_req),
    .wr_addr_in(wr_addr), .wr_info_in(wr_info), .wr_grant_out(wr_grant), .pe_req_in(pe_req),
    .pe_page_in(pe_page), .pe_info_in(pe_info), .pe_grant_out(pe_grant), .me_req_in(me_req),
    .me_grant_out(me_grant), .op_done_in(op_done), .rp_active_in(rp_active),
    .rp_abort_out(rp_abort), .fclk_en_out(fclk_en), .irq_done_out(irq_done), .irq_err_out(irq_err));

  // 100 MHz system clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    cpu.io_read(addr, rd);
    chk(rd, exp);
  endtask : rchk
  // Protection request pulse; grants come back as {bulk, page, write}
  task automatic fire(input logic [2:0] sel, output logic [7:0] gr);
    @(negedge sys_clk_in);
    {me_req, pe_req, wr_req} = sel;
    @(negedge sys_clk_in);
    gr = {5'h00, me_grant, pe_grant, wr_grant};
    {me_req, pe_req, wr_req} = 3'b000;
  endtask : fire
  // Cycles from request edge to answer; bit 7 marks a refusal
  task automatic mem_cycles(output logic [7:0] c);
    @(negedge sys_clk_in);
    mem_req = 1'b1;
    @(negedge sys_clk_in);
    mem_req = 1'b0;
    c = 8'h01;
    while (mem_ack !== 1'b1 && mem_refuse !== 1'b1 && c < 8'h14) begin
      @(negedge sys_clk_in);
      c++;
    end
    c = {mem_refuse, c[6:0]};
  endtask : mem_cycles
  // Spacing of two controller clock enables, bounded
  task automatic tick_gap(output logic [7:0] c);
    repeat (300) if (fclk_en !== 1'b1) @(negedge sys_clk_in);
    c = 8'h00;
    do begin
      @(negedge sys_clk_in);
      c++;
    end while (fclk_en !== 1'b1 && c < 8'hFF);
  endtask : tick_gap
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // Whole run is about 10k cycles; 40k leaves margin before calling it hung
  initial begin
    #400000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    foreach (rst_rows[i]) rchk(rst_rows[i][15:8], rst_rows[i][7:0]);
    $display("test reset values done");
    // Every wait count, reserved bits written as ones
    for (int w = 0; w < 8; w++) begin
      cpu.io_write(FAPC_CTRL_ADDR, {w[2:0], 5'h1F});
      rchk(FAPC_CTRL_ADDR, {w[2:0], 5'h08});
      mem_cycles(n);
      chk(n, 8'(w + 2));
    end
    cpu.io_write(FAPC_CTRL_ADDR, 8'h80);
    mem_cycles(n);
    chk(n, 8'h81);
    cpu.io_write(FAPC_IRQ_ADDR, 8'h40);
    rchk(FAPC_IRQ_ADDR, 8'h40);
    cpu.io_write(FAPC_CTRL_ADDR, 8'h88);
    $display("test wait states done");
    cpu.io_write(FAPC_FDIV_ADDR, 8'h05);
    rchk(FAPC_FDIV_ADDR, 8'h01);
    cpu.unlock_write(FAPC_FDIV_ADDR, 8'h05);
    cpu.io_write(FAPC_PROT_ADDR, 8'h00);
    rchk(FAPC_PROT_ADDR, 8'hFF);
    rchk(FAPC_FDIV_ADDR, 8'h05);
    tick_gap(n);
    chk(n, 8'h05);
    $display("test divider done");
    // One protected block at a time: its top byte refused, next block granted
    for (int b = 0; b < 8; b++) begin
      cpu.unlock_write(FAPC_PROT_ADDR, 8'h01 << b);
      wr_addr = {b[2:0], 15'h7FFF};
      fire(3'b001, g);
      chk(g, 8'h00);
      wr_addr = {3'(b + 1), 15'h0000};
      fire(3'b001, g);
      chk(g, 8'h01);
      chk({7'h00, irq_err}, 8'h01);
      rchk(FAPC_IRQ_ADDR, 8'h48);
    end
    cpu.unlock_write(FAPC_PROT_ADDR, 8'h00);
    wp = 1'b1;
    pe_page = 7'h05;
    fire(3'b011, g);
    chk(g, 8'h00);
    pe_page = 7'h10;
    fire(3'b010, g);
    chk(g, 8'h02);
    fire(3'b100, g);
    chk(g, 8'h00);
    rchk(FAPC_IRQ_ADDR, 8'h4B);
    wp = 1'b0;
    fire(3'b100, g);
    chk(g, 8'h04);
    cpu.io_write(FAPC_PROT_ADDR, 8'h00);
    {wr_info, pe_info} = 2'b11;
    fire(3'b011, g);
    chk(g, 8'h03);
    fire(3'b100, g);
    chk(g, 8'h00);
    rchk(FAPC_IRQ_ADDR, 8'h41);
    $display("test protection done");
    cpu.io_write(FAPC_IRQ_ADDR, 8'hFF);
    rchk(FAPC_IRQ_ADDR, 8'hC0);
    @(negedge sys_clk_in);
    op_done = 1'b1;
    @(negedge sys_clk_in);
    op_done = 1'b0;
    repeat (6) @(negedge sys_clk_in);
    chk({6'h00, irq_done, irq_err}, 8'h02);
    rchk(FAPC_IRQ_ADDR, 8'hE0);
    @(negedge sys_clk_in);
    chk({6'h00, irq_done, irq_err}, 8'h00);
    // Divider of two proves the watchdog counts controller clocks, not system clocks
    cpu.unlock_write(FAPC_FDIV_ADDR, 8'h02);
    rp_active = 1'b1;
    cnt = 0;
    while (rp_abort !== 1'b1 && cnt < 12000) begin
      @(negedge sys_clk_in);
      cnt++;
    end
    rp_active = 1'b0;
    chk({7'h00, cnt >= 2 * FAPC_RP_TIMEOUT - 4 && cnt <= 2 * FAPC_RP_TIMEOUT + 4}, 8'h01);
    rchk(FAPC_IRQ_ADDR, 8'hC4);
    $display("test events done");
    // Reset in mid-run restores guarded defaults
    rst_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    rst_in = 1'b0;
    rchk(FAPC_FDIV_ADDR, 8'h01);
    rchk(FAPC_PROT_ADDR, 8'hFF);
    $display("test second reset done");
    complete_run();
  end
endmodule : flash_access_protect_control_test
